/* File: core/bus_event_perf_counter.sv */
// Bus event selection, two counters, overflow flags and monitor pins
// How it works
// - Code 6BH counts completed partial transactions
// - Code 6CH counts completed I/O transactions
// - Code 6DH counts completed deferred transactions
// - Code 6EH counts completed burst transactions
// - Code 70H counts every completed transaction
// - Code 6FH counts completed memory transactions
// - Code 64H counts bus cycles receiving data
// - Code 61H counts bus cycles driving block-next
// - Code 7AH counts bus cycles driving snoop-hit
// - Code 7BH counts bus cycles driving hit-modified
// - Snoop-stall pin drive also counts for both
// - Code 7EH counts snoop stalled clocks
// - Pin control set, ratio 2:1/3:1: pulse
// - Pin control clear: toggle pins on overflow
// - Other ratios: pins untouched, counting unaffected
// - Mask 00H self only, 20H any agent for transaction codes, nothing for the others
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps

module bus_event_perf_counter #(
  parameter int CTR_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q,
  // Bus unit events
  input wire bus_evt_pkg::ev_t ev,
  // Monitor pins and interrupt
  output logic [1:0] breakpoint_monitor_pins_q,
  output logic irq_q
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    bus_evt_pkg::sel_t [1:0] sel;
    logic [1:0][CTR_W-1:0] ctr;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [3:0] ratio;
    logic [1:0] bpm;
    logic irq;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t d;
  logic [1:0] hit;
  logic [1:0] ovf;
  logic ratio_ok;

  // ********************************************************
  // Operating notes
  // ********************************************************
  // Both counters share one decoder function, so the two selects behave
  // identically; only the pins, status bits and interrupt mask bits are per counter.
  // Transaction events rely on txn_done being a single-cycle pulse from the
  // bus unit. A level held high would be counted on every core clock.
  // Bus-cycle events count on bus_tick only, so a slow bus clock does not
  // inflate the count by the core-to-bus ratio.
  // Snoop stall counts core clocks, which is why it ignores bus_tick.
  // Unit masks other than self and any count nothing at all, rather than
  // guessing at a meaning, so a stray mask reads back as a zero count.
  // A counter write beats the increment of the same cycle, but a wrap in
  // that cycle still raises the status bit, so no overflow is lost.
  // Status set wins over a write-one clear landing in the same cycle.
  // The ratio register gates only the monitor pins; counting never stops.
  // Selecting an unsupported ratio freezes the pins, a pulse included, until
  // the ratio is made legal again; software should expect a stuck pin then.
  // Read data stand for one cycle and are zero otherwise, so a bus that ORs
  // several slaves together needs no extra enable.

  // Decode one counter's selected event against the event inputs
  function automatic logic evt_hit(bus_evt_pkg::sel_t s, bus_evt_pkg::ev_t e);
    logic self_ok;
    logic any_ok;
    logic txn;
    self_ok = (s.umask == bus_evt_pkg::UMASK_SELF);
    any_ok = (s.umask == bus_evt_pkg::UMASK_ANY);
    // Transactions: own ones, or any agent's under the any mask
    txn = e.txn_done & ((self_ok & e.txn_self) | any_ok);
    evt_hit = 1'b0;
    case (s.code)
      bus_evt_pkg::EV_PARTIAL: evt_hit = txn & e.txn_partial;
      bus_evt_pkg::EV_IO: evt_hit = txn & e.txn_io;
      bus_evt_pkg::EV_DEFERRED: evt_hit = txn & e.txn_deferred;
      bus_evt_pkg::EV_BURST: evt_hit = txn & e.txn_burst;
      bus_evt_pkg::EV_ANY_TXN: evt_hit = txn;
      bus_evt_pkg::EV_MEM: evt_hit = txn & e.txn_mem;
      // Self-only events: the any mask is not a legal choice here
      bus_evt_pkg::EV_DATA_RCV: evt_hit = self_ok & e.bus_tick & e.data_rcv;
      bus_evt_pkg::EV_BNR_DRV: evt_hit = self_ok & e.bus_tick & e.bnr_drv;
      bus_evt_pkg::EV_HIT_DRV:
        evt_hit = self_ok & e.bus_tick & (e.hit_drv | e.hit_stall_drv);
      bus_evt_pkg::EV_SNOOP_HIT_MODIFIED_PIN_DRV:
        evt_hit = self_ok & e.bus_tick & (e.snoop_hit_modified_pin_drv | e.snoop_hit_modified_pin_stall_drv);
      // Stall is counted in core clocks, not bus ticks
      bus_evt_pkg::EV_SNOOP_STALL: evt_hit = self_ok & e.snoop_stall;
      default: evt_hit = 1'b0;
    endcase
  endfunction

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb
  begin
    d = q;
    d.rdata = 32'h00000000;
    // Monitor pins only work for the two documented ratios
    ratio_ok = (q.ratio == bus_evt_pkg::RATIO_2_1) || (q.ratio == bus_evt_pkg::RATIO_3_1);
    for (int i = 0; i < 2; i++)
    begin
      hit[i] = q.sel[i].en & evt_hit(q.sel[i], ev);
      ovf[i] = hit[i] & (&q.ctr[i]);
      d.ctr[i] = q.ctr[i] + CTR_W'(hit[i]);
      if (ratio_ok)
      begin
        if (q.sel[i].pin_control_bit)
          d.bpm[i] = ovf[i];
        else if (ovf[i])
          d.bpm[i] = ~q.bpm[i];
      end
      // Else the pins hold, while counting continues above
    end
    // Set wins over a write-one clear in the same cycle
    d.stat = q.stat | ovf;
    // Register writes; a counter write overrides that cycle's count
    if (wr)
    begin
      if (addr == bus_evt_pkg::ADDR_SEL0)
        d.sel[0] = bus_evt_pkg::sel_t'(wdata & bus_evt_pkg::SEL_WR_MASK);
      else if (addr == bus_evt_pkg::ADDR_SEL1)
        d.sel[1] = bus_evt_pkg::sel_t'(wdata & bus_evt_pkg::SEL_WR_MASK);
      else if (addr == bus_evt_pkg::ADDR_CTR0)
        d.ctr[0] = wdata[CTR_W-1:0];
      else if (addr == bus_evt_pkg::ADDR_CTR1)
        d.ctr[1] = wdata[CTR_W-1:0];
      else if (addr == bus_evt_pkg::ADDR_STAT)
        d.stat = (q.stat & ~wdata[1:0]) | ovf;
      else if (addr == bus_evt_pkg::ADDR_MASK)
        d.mask = wdata[1:0];
      else if (addr == bus_evt_pkg::ADDR_CFG)
        d.ratio = wdata[3:0];
    end
    // Reads answer one cycle later; unmapped reads return zero
    if (rd)
    begin
      if (addr == bus_evt_pkg::ADDR_SEL0)
        d.rdata = q.sel[0];
      else if (addr == bus_evt_pkg::ADDR_SEL1)
        d.rdata = q.sel[1];
      else if (addr == bus_evt_pkg::ADDR_CTR0)
        d.rdata = 32'(q.ctr[0]);
      else if (addr == bus_evt_pkg::ADDR_CTR1)
        d.rdata = 32'(q.ctr[1]);
      else if (addr == bus_evt_pkg::ADDR_STAT)
        d.rdata = {30'h00000000, q.stat};
      else if (addr == bus_evt_pkg::ADDR_MASK)
        d.rdata = {30'h00000000, q.mask};
      else if (addr == bus_evt_pkg::ADDR_CFG)
        d.rdata = {28'h0000000, q.ratio};
    end
    // Interrupt is registered so the pin comes straight off a flop
    d.irq = |(d.stat & d.mask);
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.ratio <= bus_evt_pkg::RATIO_RST;
    end
    else
      q <= d;
  end

  // Outputs
  assign rdata_q = q.rdata;
  assign breakpoint_monitor_pins_q = q.bpm;
  assign irq_q = q.irq;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Counter 0 writes are excluded where the count itself is checked
  logic no_wr0;
  assign no_wr0 = !(wr && addr == bus_evt_pkg::ADDR_CTR0);

  a_partial_hit: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_PARTIAL
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.txn_done && ev.txn_self && ev.txn_partial |-> hit[0])
    else $error("partial transaction not counted");

  a_io_hit: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_IO
    && hit[0] |-> ev.txn_done && ev.txn_io)
    else $error("io count without io transaction");

  a_any_txn: assert property (
    q.sel[1].en && q.sel[1].code == bus_evt_pkg::EV_ANY_TXN
    && q.sel[1].umask == bus_evt_pkg::UMASK_ANY && ev.txn_done |-> hit[1])
    else $error("any transaction not counted");

  a_snoop_hit_modified_pin_stall: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_SNOOP_HIT_MODIFIED_PIN_DRV
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.bus_tick && ev.snoop_hit_modified_pin_stall_drv |-> hit[0])
    else $error("stall hit-modified drive not counted");

  a_stall_clk: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_SNOOP_STALL
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF |-> hit[0] == ev.snoop_stall)
    else $error("snoop stall clock miscounted");

  a_self_only: assert property (
    q.sel[0].code == bus_evt_pkg::EV_BNR_DRV
    && q.sel[0].umask == bus_evt_pkg::UMASK_ANY |-> !hit[0])
    else $error("self-only event counted under any mask");

  a_ctr_step: assert property (
    no_wr0 |=> q.ctr[0] == $past(q.ctr[0]) + CTR_W'($past(hit[0])))
    else $error("counter did not step by the event");

  a_ovf_flag: assert property (
    hit[0] && (&q.ctr[0]) |=> q.stat[0] ##1 irq_q || !q.mask[0])
    else $error("overflow flag or interrupt missing");

  // Pulse mode: overflow, then pin high for one clock only
  sequence s_pulse_ovf;
    ratio_ok && q.sel[0].pin_control_bit && ovf[0];
  endsequence
  sequence s_pulse_end;
    breakpoint_monitor_pins_q[0] && ratio_ok && q.sel[0].pin_control_bit && !ovf[0];
  endsequence

  a_bpm_pulse: assert property (
    s_pulse_ovf |=> breakpoint_monitor_pins_q[0])
    else $error("monitor pin pulse missing");

  a_bpm_single: assert property (
    s_pulse_end |=> !breakpoint_monitor_pins_q[0])
    else $error("monitor pin pulse longer than one clock");

  a_bpm_toggle: assert property (
    ratio_ok && !q.sel[0].pin_control_bit && ovf[0]
    |=> breakpoint_monitor_pins_q[0] != $past(breakpoint_monitor_pins_q[0]))
    else $error("monitor pin did not toggle");

  a_bpm_hold: assert property (
    !ratio_ok |=> $stable(breakpoint_monitor_pins_q))
    else $error("monitor pins moved under unsupported ratio");

  // ********************************************************
  // Event decode checks, counter 0
  // ********************************************************
  // Self deferred transaction must count
  a_deferred_hit: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_DEFERRED
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.txn_done && ev.txn_self && ev.txn_deferred |-> hit[0])
    else $error("deferred transaction not counted");

  // Self burst transaction must count
  a_burst_hit: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_BURST
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.txn_done && ev.txn_self && ev.txn_burst |-> hit[0])
    else $error("burst transaction not counted");

  // Self memory transaction must count
  a_mem_hit: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_MEM
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.txn_done && ev.txn_self && ev.txn_mem |-> hit[0])
    else $error("memory transaction not counted");

  // Data receive counts on a bus tick
  a_rcv_hit: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_DATA_RCV
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.bus_tick && ev.data_rcv |-> hit[0])
    else $error("data receive cycle not counted");

  // Without a bus tick the data receive event never counts
  a_rcv_no_tick: assert property (
    q.sel[0].code == bus_evt_pkg::EV_DATA_RCV && !ev.bus_tick |-> !hit[0])
    else $error("data receive counted off a bus tick");

  // Block-next drive counts on a bus tick
  a_bnr_hit: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_BNR_DRV
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.bus_tick && ev.bnr_drv |-> hit[0])
    else $error("block-next drive not counted");

  // Snoop-hit drive counts on a bus tick
  a_hit_drive: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_HIT_DRV
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.bus_tick && ev.hit_drv |-> hit[0])
    else $error("snoop-hit drive not counted");

  // Hit-modified drive counts on a bus tick
  a_snoop_hit_modified_pin_drive: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_SNOOP_HIT_MODIFIED_PIN_DRV
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.bus_tick && ev.snoop_hit_modified_pin_drv |-> hit[0])
    else $error("hit-modified drive not counted");

  // Stall-driven snoop-hit also counts
  a_hit_stall: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_HIT_DRV
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF
    && ev.bus_tick && ev.hit_stall_drv |-> hit[0])
    else $error("stall snoop-hit drive not counted");

  // ********************************************************
  // Unit mask and enable checks
  // ********************************************************
  // Any mask counts another agent's transaction
  a_any_mask: assert property (
    q.sel[0].en && q.sel[0].code == bus_evt_pkg::EV_PARTIAL
    && q.sel[0].umask == bus_evt_pkg::UMASK_ANY
    && ev.txn_done && ev.txn_partial |-> hit[0])
    else $error("any-agent transaction not counted");

  // Self mask ignores another agent's transaction
  a_self_mask: assert property (
    q.sel[0].code == bus_evt_pkg::EV_PARTIAL
    && q.sel[0].umask == bus_evt_pkg::UMASK_SELF && !ev.txn_self |-> !hit[0])
    else $error("other agent counted under self mask");

  // A mask that is neither self nor any counts nothing
  a_bad_mask: assert property (
    q.sel[0].umask != bus_evt_pkg::UMASK_SELF
    && q.sel[0].umask != bus_evt_pkg::UMASK_ANY |-> !hit[0])
    else $error("event counted under an unknown mask");

  // A disabled select never counts
  a_disabled_quiet: assert property (
    !q.sel[0].en |-> !hit[0])
    else $error("disabled counter counted");

  // ********************************************************
  // Wrap and status checks
  // ********************************************************
  // Wrap from all ones lands on zero
  sequence s_wrap0;
    no_wr0 && hit[0] && (&q.ctr[0]);
  endsequence

  a_wrap_zero: assert property (
    s_wrap0 |=> q.ctr[0] == '0)
    else $error("counter did not wrap to zero");

  // Status stays set until software writes a one to it
  a_stat_sticky: assert property (
    q.stat[0] && !(wr && addr == bus_evt_pkg::ADDR_STAT && wdata[0]) |=> q.stat[0])
    else $error("overflow status dropped without a clear");

endmodule

/* File: core/bus_evt_pkg.sv */
// Shared types and constants for the bus event performance counter
package bus_evt_pkg;

  // ********************************************************
  // Register offsets (byte addresses)
  // ********************************************************
  localparam logic [7:0] ADDR_SEL0 = 8'h00;
  localparam logic [7:0] ADDR_SEL1 = 8'h04;
  localparam logic [7:0] ADDR_CTR0 = 8'h08;
  localparam logic [7:0] ADDR_CTR1 = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_CFG = 8'h18;

  // ********************************************************
  // Event codes and unit masks
  // ********************************************************
  localparam logic [7:0] EV_PARTIAL = 8'h6b;
  localparam logic [7:0] EV_IO = 8'h6c;
  localparam logic [7:0] EV_DEFERRED = 8'h6d;
  localparam logic [7:0] EV_BURST = 8'h6e;
  localparam logic [7:0] EV_MEM = 8'h6f;
  localparam logic [7:0] EV_ANY_TXN = 8'h70;
  localparam logic [7:0] EV_DATA_RCV = 8'h64;
  localparam logic [7:0] EV_BNR_DRV = 8'h61;
  localparam logic [7:0] EV_HIT_DRV = 8'h7a;
  localparam logic [7:0] EV_SNOOP_HIT_MODIFIED_PIN_DRV = 8'h7b;
  localparam logic [7:0] EV_SNOOP_STALL = 8'h7e;
  localparam logic [7:0] UMASK_SELF = 8'h00;
  localparam logic [7:0] UMASK_ANY = 8'h20;

  // Core-to-bus clock ratio codes held in the config register
  localparam logic [3:0] RATIO_2_1 = 4'h2;
  localparam logic [3:0] RATIO_3_1 = 4'h3;
  localparam logic [3:0] RATIO_RST = 4'h2;

  // ********************************************************
  // Event select layout: pin control at bit 19, enable at 22
  // ********************************************************
  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic en;
    logic [1:0] rsvd_mid;
    logic pin_control_bit;
    logic [2:0] rsvd_lo;
    logic [7:0] umask;
    logic [7:0] code;
  } sel_t;

  localparam logic [31:0] SEL_WR_MASK = 32'h0048ffff;

  // ********************************************************
  // Bus unit event inputs, all from core clock logic
  // ********************************************************
  typedef struct packed {
    logic txn_done;
    logic txn_self;
    logic txn_partial;
    logic txn_io;
    logic txn_deferred;
    logic txn_burst;
    logic txn_mem;
    logic bus_tick;
    logic data_rcv;
    logic bnr_drv;
    logic hit_drv;
    logic snoop_hit_modified_pin_drv;
    logic hit_stall_drv;
    logic snoop_hit_modified_pin_stall_drv;
    logic snoop_stall;
  } ev_t;

endpackage

/* File: verification/bus_agent_model.sv */
// Behavioural bus unit that raises the event lines seen by the counter
`timescale 1ns/1ps
module bus_agent_model (
  // Clock
  input wire logic clk,
  // Event lines toward the counter
  output bus_evt_pkg::ev_t ev
);
  // ********************************************************
  // Event source
  // ********************************************************
  // Lines stay quiet until a request, so nothing counts by accident
  initial ev = '0;

  // One core clock of activity, then every line drops again
  task automatic fire(input bus_evt_pkg::ev_t v);
    ev <= v;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask
endmodule

/* File: verification/test_bus_event_perf_counter.sv */
// Self-checking bench for the bus event performance counter
`timescale 1ns/1ps
module test_bus_event_perf_counter;
  // ********************************************************
  // Signals and tables
  // ********************************************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata_q;
  logic [1:0] breakpoint_monitor_pins_q;
  logic irq_q;
  bus_evt_pkg::ev_t ev;
  int error_cnt = 0;
  int n_compared = 0;
  // Event code in the top byte, lines that must count it below
  localparam logic [22:0] TBL [13] = '{
    {8'h6b, 15'h7000}, {8'h6c, 15'h6800}, {8'h6d, 15'h6400}, {8'h6e, 15'h6200},
    {8'h6f, 15'h6100}, {8'h70, 15'h6000}, {8'h64, 15'h00c0}, {8'h61, 15'h00a0},
    {8'h7a, 15'h0090}, {8'h7b, 15'h0088}, {8'h7a, 15'h0084}, {8'h7b, 15'h0082},
    {8'h7e, 15'h0001}};
  // Overflow cases: pin control, ratio, pin now, pin next, irq expected
  // A pulse-mode select left over drives the pin low once the ratio is legal again,
  // so the toggle case after the held-high cases starts from a low pin
  localparam logic [7:0] OVF [8] = '{8'h95, 8'h9d, 8'h17, 8'h2f, 8'haf, 8'h17, 8'h11, 8'h94};

  // Core clock, 100 ns period
  always #50 clk = ~clk;

  bus_event_perf_counter i_dut (
    .clk(clk),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata_q(rdata_q),
    .ev(ev),
    .breakpoint_monitor_pins_q(breakpoint_monitor_pins_q),
    .irq_q(irq_q)
  );

  bus_agent_model i_agent (
    .clk(clk),
    .ev(ev)
  );

  // ********************************************************
  // Register access and compare tasks
  // ********************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata_q, e);
  endtask

  // Wrap counter 0 on a snoop stall and watch pin 0 for two cycles
  task automatic ovf(input logic [7:0] c);
    wr_reg(8'h18, {28'h0, c[6:3]});
    wr_reg(8'h14, {31'h0, c[0]});
    wr_reg(8'h00, 32'h0040007e | {12'h0, c[7], 19'h0});
    wr_reg(8'h08, 32'hffffffff);
    i_agent.fire(15'h0001);
    chk({30'h0, breakpoint_monitor_pins_q}, {31'h0, c[2]});
    @(posedge clk);
    #1;
    chk({30'h0, breakpoint_monitor_pins_q}, {31'h0, c[1]});
    chk({31'h0, irq_q}, {31'h0, c[0]});
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h10, 32'h1);
    wr_reg(8'h10, 32'h3);
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ********************************************************
  // Test sequence
  // ********************************************************
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h18, 32'h2);
    rd_chk(8'h1c, 32'h0);
    wr_reg(8'h00, 32'hffffffff);
    rd_chk(8'h00, 32'h0048ffff);
    $display("test reset_map done");
    // Second pulse lacks completion and bus tick, so only snoop stall counts it
    for (int i = 0; i < 13; i++)
    begin
      wr_reg(8'h08, 32'h0);
      wr_reg(8'h00, {9'h0, 1'b1, 14'h0, TBL[i][22:15]});
      i_agent.fire(TBL[i][14:0]);
      i_agent.fire(TBL[i][14:0] & 15'h3f7f);
      rd_chk(8'h08, (TBL[i][22:15] == 8'h7e) ? 32'h2 : 32'h1);
    end
    $display("test event_codes done");
    // Another agent's partial transaction under both unit masks
    wr_reg(8'h08, 32'h0);
    wr_reg(8'h00, 32'h0040006b);
    i_agent.fire(15'h5000);
    rd_chk(8'h08, 32'h0);
    wr_reg(8'h00, 32'h0040206b);
    i_agent.fire(15'h5000);
    rd_chk(8'h08, 32'h1);
    wr_reg(8'h00, 32'h0040207e);
    i_agent.fire(15'h0001);
    rd_chk(8'h08, 32'h1);
    wr_reg(8'h00, 32'h0040106b);
    i_agent.fire(15'h7000);
    rd_chk(8'h08, 32'h1);
    wr_reg(8'h00, 32'h00402061);
    i_agent.fire(15'h00a0);
    rd_chk(8'h08, 32'h1);
    wr_reg(8'h04, 32'h0040006c);
    i_agent.fire(15'h6800);
    rd_chk(8'h0c, 32'h1);
    wr_reg(8'h04, 32'h00402070);
    i_agent.fire(15'h5000);
    rd_chk(8'h0c, 32'h2);
    $display("test unit_mask done");
    foreach (OVF[i])
      ovf(OVF[i]);
    $display("test overflow done");
    end_sim();
  end

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
